// ---- uart_modem_pkg.sv ----
package uart_modem_pkg;
   // Modem status layout: change flags low, line levels high
   localparam int ST_CTS_CHG = 0;
   localparam int ST_DSR_CHG = 1;
   localparam int ST_RING_END = 2;
   localparam int ST_DCD_CHG = 3;
   localparam int ST_CTS = 4;
   localparam int ST_DSR = 5;
   localparam int ST_RI = 6;
   localparam int ST_DCD = 7;
   // Modem control layout
   localparam int CT_DTR = 0;
   localparam int CT_RTS = 1;
   localparam int CT_USER_A = 2;
   localparam int CT_USER_B = 3;
   localparam int CT_LOOP = 4;
   localparam int CT_W = 5;
   localparam logic [4:0] CT_RESET = 5'h00;
   // Interrupt enable layout
   localparam int IER_RDA = 0;
   localparam int IER_THR = 1;
   localparam int IER_RLS = 2;
   localparam int IER_MS = 3;
   // Positions in the synchronised pin vector
   localparam int SY_CTS_N = 0;
   localparam int SY_DSR_N = 1;
   localparam int SY_RI_N = 2;
   localparam int SY_DCD_N = 3;
   localparam int SY_RD_N = 4;
   localparam int SY_WR_N = 5;
   localparam int SY_STAT_SEL = 6;
   localparam int SY_CTRL_SEL = 7;
   localparam int SY_MRESET = 8;
   localparam int SY_DATA = 9;
   localparam int SY_W = 17;
   localparam logic [16:0] SY_RESET = 17'h0003F;
   localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

// ---- modem_track_if.sv ----
`timescale 1ns/1ns
// Carries line levels to the change tracker and its flags back
interface modem_track_if;
   logic [3:0] level;
   logic clear;
   logic mreset;
   logic [3:0] delta;
   modport src (output level, output clear, output mreset, input delta);
   modport trk (input level, input clear, input mreset, output delta);
endinterface

// ---- pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 17,
   parameter logic [16:0] RESET_VAL = 17'h00000
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_sync_out
);
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage2_q;

   // Two-flop synchroniser; only the second stage is read
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stage1_q <= RESET_VAL[W-1:0];
         stage2_q <= RESET_VAL[W-1:0];
      end else begin
         stage1_q <= pin_in;
         stage2_q <= stage1_q;
      end
   end

   assign pin_sync_out = stage2_q;
endmodule

// ---- modem_change_tracker.sv ----
`timescale 1ns/1ns
module modem_change_tracker
   import uart_modem_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   modem_track_if.trk trk
);
   logic [3:0] prev_q;
   logic [3:0] prev_d;
   logic [3:0] delta_q;
   logic [3:0] delta_d;
   logic [3:0] change;

   // Level changes set sticky flags; a set in the clearing cycle wins
   always_comb begin
      change = trk.level ^ prev_q;
      // Ring indicator flags only on the trailing edge
      change[ST_RING_END] = prev_q[ST_RING_END] & ~trk.level[ST_RING_END];
      prev_d = trk.level;
      delta_d = (delta_q & ~{4{trk.clear}}) | change;
      if (trk.mreset) begin
         delta_d = 4'h0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prev_q <= 4'h0;
         delta_q <= 4'h0;
      end else begin
         prev_q <= prev_d;
         delta_q <= delta_d;
      end
   end

   assign trk.delta = delta_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   set_wins_a: assert property ((trk.level[ST_DCD_CHG] != prev_q[ST_DCD_CHG]) && !trk.mreset && trk.clear
      |=> delta_q[ST_DCD_CHG])
      else $error("carrier change lost in clearing cycle");
   clear_hold_a: assert property (trk.clear && change == 4'h0 |=> delta_q == 4'h0)
      else $error("flags survived a status read");
endmodule

// ---- uart_modem_signal_logic.sv ----
`timescale 1ns/1ns
module uart_modem_signal_logic
   import uart_modem_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic master_reset,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic dcd_n,
   input wire logic cpu_rd_n,
   input wire logic cpu_wr_n,
   input wire logic status_sel,
   input wire logic control_sel,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_n,
   output logic read_driver_disable,
   input wire logic [3:0] int_enable,
   input wire logic auto_cts_en,
   input wire logic fifo_mode,
   input wire logic rx_error,
   input wire logic rx_data_avail,
   input wire logic rx_timeout,
   input wire logic thr_empty,
   output logic tx_permit,
   output logic dtr_n,
   output logic rts_n,
   output logic user_output_a,
   output logic user_output_b,
   output logic int_out
);
   // Rising edge of an active-high level
   function automatic logic rise(input logic prev, input logic cur);
      return cur & ~prev;
   endfunction

   logic [SY_W-1:0] sy;
   logic rd_act;
   logic wr_act;
   logic rd_rise;
   logic wr_rise;
   logic mreset;
   logic [3:0] pin_level;
   logic [3:0] level;
   logic [7:0] modem_status_reg;
   logic ms_pending;
   logic pending;
   logic [CT_W-1:0] modem_control_reg;
   logic [CT_W-1:0] ctrl_d;
   logic rd_prev_q;
   logic rd_prev_d;
   logic wr_prev_q;
   logic wr_prev_d;
   logic [7:0] data_q;
   logic [7:0] data_d;
   logic oe_n_q;
   logic oe_n_d;
   logic rdd_q;
   logic rdd_d;
   logic dtr_n_q;
   logic dtr_n_d;
   logic rts_n_q;
   logic rts_n_d;
   logic out_a_q;
   logic out_a_d;
   logic out_b_q;
   logic out_b_d;
   logic int_q;
   logic int_d;
   logic tx_ok_q;
   logic tx_ok_d;

   modem_track_if trk_if ();

   // Bus, strobe, select, reset and modem line pins pass two flops; interrupt source and mode inputs do not
   pin_sync #(.W(SY_W), .RESET_VAL(SY_RESET)) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pin_in({data_in, master_reset, control_sel, status_sel, cpu_wr_n, cpu_rd_n, dcd_n, ri_n, dsr_n, cts_n}),
      .pin_sync_out(sy)
   );

   modem_change_tracker u_track (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .trk(trk_if.trk)
   );

   // Strobe decode and line levels; loopback feeds control bits back
   always_comb begin
      rd_act = ~sy[SY_RD_N];
      wr_act = ~sy[SY_WR_N];
      rd_rise = rise(rd_prev_q, rd_act);
      wr_rise = rise(wr_prev_q, wr_act);
      mreset = sy[SY_MRESET];
      pin_level = ~{sy[SY_DCD_N], sy[SY_RI_N], sy[SY_DSR_N], sy[SY_CTS_N]};
      if (modem_control_reg[CT_LOOP]) begin
         level = {modem_control_reg[CT_USER_B], modem_control_reg[CT_USER_A],
                  modem_control_reg[CT_DTR], modem_control_reg[CT_RTS]};
      end else begin
         level = pin_level;
      end
   end

   assign trk_if.level = level;
   assign trk_if.clear = rd_rise & sy[SY_STAT_SEL];
   assign trk_if.mreset = mreset;
   assign modem_status_reg = {level, trk_if.delta};

   // Interrupt sources and their enables
   always_comb begin
      ms_pending = trk_if.delta[ST_DSR_CHG] | trk_if.delta[ST_RING_END] | trk_if.delta[ST_DCD_CHG]
                   | (trk_if.delta[ST_CTS_CHG] & ~auto_cts_en);
      pending = (int_enable[IER_RLS] & rx_error)
                | (int_enable[IER_RDA] & (rx_data_avail | (rx_timeout & fifo_mode)))
                | (int_enable[IER_THR] & thr_empty)
                | (int_enable[IER_MS] & ms_pending);
   end

   // Next values of control register, bus and output pins
   always_comb begin
      rd_prev_d = rd_act;
      wr_prev_d = wr_act;
      // Control register: master reset wins over a write
      ctrl_d = modem_control_reg;
      if (mreset) begin
         ctrl_d = CT_RESET;
      end else if (wr_rise && sy[SY_CTRL_SEL]) begin
         ctrl_d = sy[SY_DATA +: CT_W];
      end
      // Read data captured once at the start of a read
      data_d = data_q;
      if (rd_rise) begin
         if (sy[SY_STAT_SEL]) begin
            data_d = modem_status_reg;
         end else if (sy[SY_CTRL_SEL]) begin
            data_d = {3'h0, modem_control_reg};
         end else begin
            data_d = DATA_RESET;
         end
      end
      // Bus enable and driver disable follow the read strobe
      oe_n_d = ~(rd_act & (sy[SY_STAT_SEL] | sy[SY_CTRL_SEL]));
      rdd_d = ~rd_act;
      // Modem outputs are forced inactive in loopback
      dtr_n_d = ~(modem_control_reg[CT_DTR] & ~modem_control_reg[CT_LOOP]);
      rts_n_d = ~(modem_control_reg[CT_RTS] & ~modem_control_reg[CT_LOOP]);
      out_a_d = ~(modem_control_reg[CT_USER_A] & ~modem_control_reg[CT_LOOP]);
      out_b_d = ~(modem_control_reg[CT_USER_B] & ~modem_control_reg[CT_LOOP]);
      // Interrupt and transmit permission
      int_d = pending & ~mreset;
      tx_ok_d = ~auto_cts_en | level[0];
      if (mreset) begin
         dtr_n_d = 1'b1;
         rts_n_d = 1'b1;
         out_a_d = 1'b1;
         out_b_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
         modem_control_reg <= CT_RESET;
         data_q <= DATA_RESET;
         oe_n_q <= 1'b1;
         rdd_q <= 1'b1;
         dtr_n_q <= 1'b1;
         rts_n_q <= 1'b1;
         out_a_q <= 1'b1;
         out_b_q <= 1'b1;
         int_q <= 1'b0;
         tx_ok_q <= 1'b1;
      end else begin
         rd_prev_q <= rd_prev_d;
         wr_prev_q <= wr_prev_d;
         modem_control_reg <= ctrl_d;
         data_q <= data_d;
         oe_n_q <= oe_n_d;
         rdd_q <= rdd_d;
         dtr_n_q <= dtr_n_d;
         rts_n_q <= rts_n_d;
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
         int_q <= int_d;
         tx_ok_q <= tx_ok_d;
      end
   end

   assign data_out = data_q;
   assign data_oe_n = oe_n_q;
   assign read_driver_disable = rdd_q;
   assign dtr_n = dtr_n_q;
   assign rts_n = rts_n_q;
   assign user_output_a = out_a_q;
   assign user_output_b = out_b_q;
   assign int_out = int_q;
   assign tx_permit = tx_ok_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // Status bits returned on a read carry the line levels
   stat_cts_bit_a: assert property (rd_rise && sy[SY_STAT_SEL] |=> data_out[ST_CTS] == $past(level[0]))
      else $error("status read lost clear-to-send level");
   stat_dcd_bit_a: assert property (rd_rise && sy[SY_STAT_SEL] |=> data_out[ST_DCD] == $past(level[3]))
      else $error("status read lost carrier level");
   stat_dsr_bit_a: assert property (rd_rise && sy[SY_STAT_SEL] |=> data_out[ST_DSR] == $past(level[1]))
      else $error("status read lost data-set-ready level");

   // Change flags appear one edge after the level moves
   cts_flag_set_a: assert property ($changed(level[0]) && !mreset |=> trk_if.delta[ST_CTS_CHG])
      else $error("clear-to-send change not flagged");
   dcd_flag_set_a: assert property ($changed(level[3]) && !mreset |=> trk_if.delta[ST_DCD_CHG])
      else $error("carrier change not flagged");
   dsr_flag_set_a: assert property ($changed(level[1]) && !mreset |=> trk_if.delta[ST_DSR_CHG])
      else $error("data-set-ready change not flagged");

   // Modem interrupts follow the flags while enabled
   cts_auto_quiet_a: assert property (auto_cts_en && trk_if.delta == 4'h1 && !rx_error
      && !rx_data_avail && !rx_timeout && !thr_empty |=> !int_out)
      else $error("auto mode let clear-to-send interrupt");
   cts_int_a: assert property ($changed(level[0]) && !mreset ##1
      !mreset && int_enable[IER_MS] && !auto_cts_en |=> int_out)
      else $error("clear-to-send change did not interrupt");
   dcd_int_a: assert property ($changed(level[3]) && !mreset ##1
      !mreset && int_enable[IER_MS] |=> int_out)
      else $error("carrier change did not interrupt");
   dsr_int_a: assert property ($changed(level[1]) && !mreset ##1
      !mreset && int_enable[IER_MS] |=> int_out)
      else $error("data-set-ready change did not interrupt");

   // Transmit permission in and out of auto mode
   tx_hold_a: assert property (auto_cts_en && !level[0] |=> !tx_permit)
      else $error("transmission allowed without clear-to-send");
   tx_go_a: assert property (!auto_cts_en |=> tx_permit)
      else $error("transmission held outside auto mode");

   // Driver disable tracks the read strobe
   read_read_driver_disable_a: assert property (rd_act |=> !read_driver_disable ##1 (read_driver_disable == !$past(rd_act)))
      else $error("driver disable wrong around read");
   read_driver_disable_high_a: assert property (!rd_act |=> read_driver_disable)
      else $error("driver disable low outside a read");

   // Modem control outputs
   dtr_active_a: assert property (modem_control_reg[CT_DTR] && !modem_control_reg[CT_LOOP] && !mreset
      |=> !dtr_n)
      else $error("terminal ready not driven active");
   dtr_inactive_a: assert property (modem_control_reg[CT_LOOP] || mreset |=> dtr_n)
      else $error("terminal ready active in loopback or reset");
   rts_active_a: assert property (modem_control_reg[CT_RTS] && !modem_control_reg[CT_LOOP] && !mreset
      |=> !rts_n)
      else $error("request to send not driven active");
   rts_idle_a: assert property (modem_control_reg[CT_LOOP] || mreset |=> rts_n)
      else $error("request to send active in loopback or reset");
   user_out_a: assert property (modem_control_reg[CT_USER_A] && !modem_control_reg[CT_LOOP] && !mreset
      |=> !user_output_a)
      else $error("first user output not active");
   user_b_out_a: assert property (modem_control_reg[CT_USER_B] && !modem_control_reg[CT_LOOP] && !mreset
      |=> !user_output_b)
      else $error("second user output not active");
   user_idle_a: assert property (modem_control_reg[CT_LOOP] || mreset |=> user_output_a && user_output_b)
      else $error("user outputs active in loopback or reset");
   ctrl_write_a: assert property (wr_rise && sy[SY_CTRL_SEL] && !mreset
      |=> modem_control_reg == $past(sy[SY_DATA +: CT_W]))
      else $error("control write not taken");

   // Interrupt output
   int_raise_a: assert property (pending && !mreset |=> int_out)
      else $error("pending source not signalled");
   int_drop_a: assert property (!pending || mreset |=> !int_out)
      else $error("interrupt held after service or reset");
   mreset_int_a: assert property (mreset |=> !int_out)
      else $error("interrupt held in master reset");

   // Bus drive and status read side effects
   bus_release_a: assert property (!data_oe_n |-> $past(rd_act))
      else $error("bus driven outside a read");
   bus_drive_a: assert property (rd_act && (sy[SY_STAT_SEL] || sy[SY_CTRL_SEL]) |=> !data_oe_n)
      else $error("bus not driven during a selected read");
   stat_clear_a: assert property (rd_rise && sy[SY_STAT_SEL] && $stable(level) && !mreset
      |=> trk_if.delta == 4'h0)
      else $error("status read left change flags");

   status_read_c: cover property (rd_rise && sy[SY_STAT_SEL] && trk_if.delta != 4'h0);
   ms_int_c: cover property (int_enable[IER_MS] && ms_pending ##1 int_out);
   loopback_c: cover property (modem_control_reg[CT_LOOP] && level[1]);
   auto_hold_c: cover property (auto_cts_en && !tx_permit);
   ctrl_write_c: cover property (wr_rise && sy[SY_CTRL_SEL]);
endmodule

// ---- modem_model.sv ----
`timescale 1ns/1ns
// Modem side: turns requested line states into active-low status lines
module modem_model (
   input wire logic [3:0] line_on,
   output logic cts_n,
   output logic dsr_n,
   output logic ri_n,
   output logic dcd_n
);
   // Bit order of line_on: 0 clear-to-send, 1 set ready, 2 ring, 3 carrier
   always_comb begin
      {dcd_n, ri_n, dsr_n, cts_n} = ~line_on;
   end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
   import uart_modem_pkg::*;
   logic sys_clk = 0, rstn = 0, master_reset = 0, cpu_rd_n = 1, cpu_wr_n = 1;
   logic status_sel = 0, control_sel = 0, cpu_oe = 0, auto_cts_en = 0, fifo_mode = 0;
   logic [7:0] ctrl_v = 8'h00;
   logic rx_error = 0, rx_data_avail = 0, rx_timeout = 0, thr_empty = 0;
   logic [7:0] cpu_d = 8'h00;
   logic [7:0] bus, data_out;
   logic [3:0] int_enable = 4'h0, line_on = 4'h0, delta_q = 4'h0, nxt;
   logic data_oe_n, read_driver_disable, tx_permit, dtr_n, rts_n;
   logic user_output_a, user_output_b, int_out, cts_n, dsr_n, ri_n, dcd_n;
   int n_mismatch = 0, checks_done = 0;

   // Bus wire: device, then CPU, else pulled high
   assign bus = !data_oe_n ? data_out : (cpu_oe ? cpu_d : 8'hFF);

   always #50 sys_clk = ~sys_clk;

   modem_model modem (.line_on(line_on), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

   uart_modem_signal_logic dut (.sys_clk(sys_clk), .rstn(rstn), .master_reset(master_reset),
      .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .cpu_rd_n(cpu_rd_n),
      .cpu_wr_n(cpu_wr_n), .status_sel(status_sel), .control_sel(control_sel), .data_in(bus),
      .data_out(data_out), .data_oe_n(data_oe_n), .read_driver_disable(read_driver_disable),
      .int_enable(int_enable), .auto_cts_en(auto_cts_en), .fifo_mode(fifo_mode),
      .rx_error(rx_error), .rx_data_avail(rx_data_avail), .rx_timeout(rx_timeout),
      .thr_empty(thr_empty), .tx_permit(tx_permit), .dtr_n(dtr_n), .rts_n(rts_n),
      .user_output_a(user_output_a), .user_output_b(user_output_b), .int_out(int_out));

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_byte({7'h00, got}, {7'h00, exp}, what);
   endtask

   // Change flags expected from old and new line states; ring flags on its trailing edge
   function automatic logic [3:0] new_flags(input logic [3:0] o, input logic [3:0] n);
      logic [3:0] x;
      x = o ^ n;
      return {x[3], o[2] & ~n[2], x[1], x[0]};
   endfunction

   // Modem interrupt: clear-to-send change masked in auto mode
   function automatic logic exp_int(input logic [3:0] d);
      return int_enable[3] & ((|d[3:1]) | (d[0] & ~auto_cts_en));
   endfunction

   // Levels seen by the device: loopback mirrors rts, dtr, user a, user b
   function automatic logic [3:0] exp_level();
      return ctrl_v[4] ? {ctrl_v[3], ctrl_v[2], ctrl_v[0], ctrl_v[1]} : line_on;
   endfunction

   task automatic set_lines(input logic [3:0] n);
      delta_q = delta_q | new_flags(line_on, n);
      line_on = n;
      cyc(6);
   endtask

   // Status read; mask hides bits that a scenario does not predict
   task automatic read_status(input logic [7:0] m);
      status_sel = 1;
      cpu_rd_n = 0;
      cyc(4);
      chk_byte(data_out & m, {exp_level(), delta_q} & m, "status");
      chk_bit(data_oe_n, 0, "bus drive");
      chk_bit(read_driver_disable, 0, "driver low");
      cpu_rd_n = 1;
      cyc(4);
      status_sel = 0;
      chk_bit(data_oe_n, 1, "bus release");
      chk_bit(read_driver_disable, 1, "driver high");
      delta_q = 4'h0;
      chk_bit(int_out, 0, "flags cleared");
   endtask

   task automatic write_ctrl(input logic [7:0] v);
      ctrl_v = v;
      cpu_d = v;
      cpu_oe = 1;
      cyc(2);
      control_sel = 1;
      cpu_wr_n = 0;
      cyc(3);
      cpu_wr_n = 1;
      cyc(1);
      control_sel = 0;
      cpu_oe = 0;
      cyc(3);
      chk_bit(dtr_n, !(v[0] & !v[4]), "terminal ready");
      chk_bit(rts_n, !(v[1] & !v[4]), "request to send");
      chk_bit(user_output_a, !(v[2] & !v[4]), "user a");
      chk_bit(user_output_b, !(v[3] & !v[4]), "user b");
      control_sel = 1;
      cpu_rd_n = 0;
      cyc(4);
      chk_byte(data_out, {3'h0, v[4:0]}, "control readback");
      chk_bit(data_oe_n, 0, "control bus drive");
      cpu_rd_n = 1;
      cyc(4);
      control_sel = 0;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run of under a thousand cycles
   initial begin
      #5000000;
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      void'($urandom(65));
      cyc(20);
      rstn = 1;
      cyc(3);
      write_ctrl(8'h00);
      chk_bit(int_out, 0, "int after reset");
      chk_bit(tx_permit, 1, "permit after reset");
      $display("test reset done");
      // Control bits alone and together, then loopback with line mirroring
      for (int i = 0; i < 4; i++) begin
         write_ctrl(8'h01 << i);
      end
      write_ctrl(8'hEF);
      write_ctrl(8'h15);
      read_status(8'hF0);
      write_ctrl(8'h1A);
      read_status(8'hF0);
      write_ctrl(8'h00);
      read_status(8'hF0);
      $display("test control done");
      // Each receive and transmit interrupt source alone, enabled then masked
      fifo_mode = 1;
      for (int i = 0; i < 8; i++) begin
         {rx_timeout, rx_error, thr_empty, rx_data_avail} = 4'h1 << i[1:0];
         int_enable = i[2] ? 4'h0 : (i[1:0] == 2'd3 ? 4'h1 : 4'h1 << i[1:0]);
         cyc(3);
         chk_bit(int_out, !i[2], "int source");
         {rx_timeout, rx_error, thr_empty, rx_data_avail} = 4'h0;
         cyc(3);
         chk_bit(int_out, 0, "int serviced");
      end
      fifo_mode = 0;
      rx_timeout = 1;
      int_enable = 4'h1;
      cyc(3);
      chk_bit(int_out, 0, "timeout outside fifo mode");
      rx_timeout = 0;
      $display("test sources done");
      // Random modem line changes, modes and reads
      for (int i = 0; i < 40; i++) begin
         int_enable = 4'($urandom);
         auto_cts_en = 1'($urandom);
         nxt = 4'($urandom);
         set_lines(nxt);
         chk_bit(int_out, exp_int(delta_q), "modem int");
         chk_bit(tx_permit, !auto_cts_en | line_on[0], "permit");
         if ($urandom % 3 == 0 || i == 39) begin
            read_status(8'hFF);
         end
      end
      $display("test modem done");
      // Unselected read leaves the bus alone
      cpu_rd_n = 0;
      cyc(4);
      chk_byte(data_out, 8'h00, "unselected data");
      chk_bit(data_oe_n, 1, "unselected bus");
      cpu_rd_n = 1;
      cyc(4);
      // Master reset with outputs active and a modem change pending
      write_ctrl(8'h0F);
      int_enable = 4'h8;
      set_lines(~line_on);
      chk_bit(int_out, 1, "pending before reset");
      master_reset = 1;
      cyc(5);
      chk_bit(int_out, 0, "int on master reset");
      chk_bit(dtr_n, 1, "ready on master reset");
      chk_bit(user_output_a, 1, "user a on master reset");
      chk_bit(user_output_b, 1, "user b on master reset");
      master_reset = 0;
      delta_q = 4'h0;
      cyc(3);
      read_status(8'hFF);
      $display("test master reset done");
      print_verdict();
   end
endmodule
